// ==== rtl/chba_adapter.sv ====
// host bus adapter between the display controller and a multiplexed
// or a demultiplexed host bus; arbitration flops emulated synchronously
// assumes all pin inputs are asynchronous and pass the 3-stage filter
`timescale 1ns/1ps
`include "chba_regs.svh"

// Behaviour
// - linear configuration bit set gives full 24-bit addressing
// - demultiplexed host: address strobe held low when controller not owner
// - as master on a demultiplexed host the controller drives both byte strobes together
// - controller bus requests are ignored while display enable is low
// - vector output in acknowledge cycles when no-vector bit is 0 and the chain enable input is high, during the slave data strobe
module chba_adapter
    import chba_pkg::*;
#(
    parameter int BR_HOLD_CYC = `CHBA_BR_HOLD_CYC,
    parameter int WAIT_CYC    = `CHBA_WAIT_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // configuration
    input  wire chba_host_t  host_kind_i,
    input  wire logic        linear_mode_i,
    input  wire logic        vector_suppress_i,
    input  wire logic        display_enable_i,
    // asynchronous pins
    input  wire chba_pins_t  pins_i,
    input  wire logic        host_wr_n_i,
    input  wire logic        ale_i,
    input  wire logic        xfer_direction_i,
    // upper address
    output logic [7:0]       upper_addr_o,
    output logic             upper_addr_oe_o,
    // translated controller strobes
    output chba_drive_t      data_strobe_n_o,
    output chba_drive_t      addr_strobe_n_o,
    output chba_drive_t      write_not_read_o,
    output chba_drive_t      mem_io_o,
    output chba_drive_t      high_byte_strobe_n_o,
    output chba_drive_t      low_byte_strobe_n_o,
    // arbitration
    output logic             hold_o,
    output chba_drive_t      host_bus_request_n_o,
    output logic             grant_confirm_n_o,
    output logic             bus_ack_in_n_o,
    output logic             bus_owner_o,
    // slave timing, data path, interrupt vector
    output logic             wait_o,
    output logic             xcvr_en_o,
    output logic             vector_en_o
);

    localparam int PW = $bits(chba_pins_t) + 3;

    // three-stage filter: a change counts once stages two and three agree
    logic [PW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    wire  [PW-1:0] raw = {pins_i, host_wr_n_i, ale_i, xfer_direction_i};

    always_ff @(posedge mclk_i) begin
        // stages reset to the idle level, else a false strobe edge follows reset
        s1_reg   <= reset_i ? {PW{`CHBA_SYNC_RESET_VAL}} : raw;
        s2_reg   <= reset_i ? {PW{`CHBA_SYNC_RESET_VAL}} : s1_reg;
        s3_reg   <= reset_i ? {PW{`CHBA_SYNC_RESET_VAL}} : s2_reg;
        filt_reg <= reset_i ? {PW{`CHBA_SYNC_RESET_VAL}} :
                    ((s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg)));
    end

    chba_pins_t p;
    logic       wr_n_f, ale_f, dtr_f;
    assign {p, wr_n_f, ale_f, dtr_f} = filt_reg;

    logic       cas_prev_reg, hrd_prev_reg;
    logic       request_flop_reg, grant_flop_reg, owner_reg;
    logic [7:0] upper_reg;
    logic [$clog2(BR_HOLD_CYC+1)-1:0] br_hold_reg;
    logic [$clog2(WAIT_CYC+1)-1:0]    wait_reg;

    wire is_mux   = (host_kind_i == CHBA_HOST_MUX);
    wire is_demux = (host_kind_i == CHBA_HOST_DEMUX);

    // a request counts only once the display is running
    wire crtc_req      = ~p.crtc_bus_request_n & display_enable_i;
    wire grant_take    = ~p.host_bus_grant_n & p.host_addr_strobe_n
                         & request_flop_reg & grant_flop_reg;
    wire grant_release = ~crtc_req | p.preempt_req;
    wire ack_low       = ~grant_flop_reg;

    // upper address capture on the strobe's trailing edge
    wire cas_rise   = p.crtc_addr_strobe_n & ~cas_prev_reg;
    wire addr_load  = cas_rise & owner_reg & ~p.crtc_write;
    wire [7:0] amask = linear_mode_i ? 8'hff : 8'h7f;

    wire slave_ds_mux   = host_rd_n_f_and(p.host_rd_n, wr_n_f);
    wire slave_ds_demux = p.high_byte_strobe_n | p.low_byte_strobe_n;
    wire slave_ds_n     = is_mux ? slave_ds_mux : slave_ds_demux;
    wire rd_fall        = ~p.host_rd_n & hrd_prev_reg & ~p.host_cs_n & is_mux;

    function automatic logic host_rd_n_f_and(input logic rd_n, input logic wrn);
        host_rd_n_f_and = rd_n & wrn;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            request_flop_reg <= 1'b0;
            grant_flop_reg   <= 1'b1;
            owner_reg        <= 1'b0;
            cas_prev_reg     <= 1'b1;
            hrd_prev_reg     <= 1'b1;
            upper_reg        <= 8'h00;
            br_hold_reg      <= '0;
            wait_reg         <= '0;
        end else begin
            cas_prev_reg <= p.crtc_addr_strobe_n;
            hrd_prev_reg <= p.host_rd_n;
            if (grant_take) begin
                grant_flop_reg   <= 1'b0;
                request_flop_reg <= 1'b0;
            end else if (grant_release) begin
                grant_flop_reg   <= 1'b1;
                request_flop_reg <= crtc_req & ~owner_reg & ~p.preempt_req;
            end else if (grant_flop_reg && !owner_reg) begin
                request_flop_reg <= crtc_req;
            end
            if (!crtc_req)
                owner_reg <= 1'b0;
            else if (ack_low)
                owner_reg <= 1'b1;
            if (grant_take)
                br_hold_reg <= ($clog2(BR_HOLD_CYC+1))'(BR_HOLD_CYC);
            else if (br_hold_reg != '0)
                br_hold_reg <= br_hold_reg - 1'b1;
            if (rd_fall)
                wait_reg <= ($clog2(WAIT_CYC+1))'(WAIT_CYC);
            else if (wait_reg != '0)
                wait_reg <= wait_reg - 1'b1;
            if (addr_load)
                upper_reg <= p.ad_low & amask;
        end
    end

    wire host_owns = ~owner_reg;

    assign upper_addr_o    = upper_reg;
    assign upper_addr_oe_o = owner_reg;

    assign data_strobe_n_o  = '{value: slave_ds_n, oe: host_owns};
    // demux slave keeps the strobe low so the select latches stay open
    assign addr_strobe_n_o  = '{value: is_mux ? ~ale_f : 1'b0,
                                oe: host_owns};
    assign write_not_read_o = '{value: ~dtr_f, oe: host_owns & is_mux};
    assign mem_io_o         = '{value: 1'b1, oe: owner_reg & is_mux};
    assign high_byte_strobe_n_o = '{value: p.crtc_data_strobe_n,
                                    oe: owner_reg & is_demux};
    assign low_byte_strobe_n_o  = '{value: p.crtc_data_strobe_n,
                                    oe: owner_reg & is_demux};

    assign hold_o               = crtc_req & is_mux;
    wire   br_low               = request_flop_reg | (br_hold_reg != '0);
    assign host_bus_request_n_o = '{value: 1'b0, oe: br_low & is_demux};
    assign grant_confirm_n_o    = grant_flop_reg;
    assign bus_ack_in_n_o       = grant_flop_reg;
    assign bus_owner_o          = owner_reg;
    assign wait_o               = (wait_reg != '0);
    // turned off as soon as the read strobe rises, ahead of next address
    assign xcvr_en_o   = owner_reg & ~p.crtc_data_strobe_n & ~p.crtc_write;
    assign vector_en_o = ~vector_suppress_i & ~p.irq_ack_cycle_n
                         & p.chain_enable_in & ~slave_ds_n;

    a_grant_take_ack: assert property (@(posedge mclk_i) disable iff (reset_i)
        grant_take |=> !grant_confirm_n_o && !bus_ack_in_n_o)
        else $error("grant not acknowledged");
    a_grant_drops_req: assert property (@(posedge mclk_i) disable iff (reset_i)
        grant_take |=> !request_flop_reg)
        else $error("request flop not cleared");
    a_br_hold_time: assert property (@(posedge mclk_i) disable iff (reset_i)
        grant_take && is_demux |=> host_bus_request_n_o.oe [*4])
        else $error("host request released too early");
    a_ack_until_rel: assert property (@(posedge mclk_i) disable iff (reset_i)
        !grant_confirm_n_o && crtc_req && !p.preempt_req |=> !grant_confirm_n_o)
        else $error("acknowledge dropped early");
    a_owner_release: assert property (@(posedge mclk_i) disable iff (reset_i)
        !crtc_req |=> !bus_owner_o)
        else $error("ownership kept after release");
    a_addr_oe_owner: assert property (@(posedge mclk_i) disable iff (reset_i)
        upper_addr_oe_o |-> $past(crtc_req))
        else $error("upper address driven without ownership");
    a_addr_load_cond: assert property (@(posedge mclk_i) disable iff (reset_i)
        $changed(upper_addr_o) |-> $past(owner_reg && !p.crtc_write && cas_rise))
        else $error("upper address loaded outside update cycle");
    a_seg_mask: assert property (@(posedge mclk_i) disable iff (reset_i)
        addr_load && !linear_mode_i |=> !upper_addr_o[7])
        else $error("segmented capture kept bit 7");
    a_drv_exclusive: assert property (@(posedge mclk_i) disable iff (reset_i)
        !(data_strobe_n_o.oe && high_byte_strobe_n_o.oe))
        else $error("strobe drivers overlap");
    a_wait_len: assert property (@(posedge mclk_i) disable iff (reset_i)
        rd_fall |=> wait_o [*8])
        else $error("wait state too short");
    c_grant: cover property (@(posedge mclk_i) disable iff (reset_i) grant_take);
    c_preempt: cover property (@(posedge mclk_i) disable iff (reset_i)
        bus_owner_o && p.preempt_req);
    c_vector: cover property (@(posedge mclk_i) disable iff (reset_i) vector_en_o);

endmodule

// ==== rtl/chba_regs.svh ====
// constants of the display-controller host bus adapter
// assumes a 200 MHz adapter clock; all times convert to whole cycles
`ifndef CHBA_REGS_SVH
`define CHBA_REGS_SVH

`define CHBA_CLK_MHZ         200
`define CHBA_SEG_ADDR_BITS   7
`define CHBA_LIN_ADDR_BITS   8
`define CHBA_BR_HOLD_NS      20
// least time: round up
`define CHBA_BR_HOLD_CYC     ((`CHBA_BR_HOLD_NS * `CHBA_CLK_MHZ + 999) / 1000)
`define CHBA_WAIT_NS         125
`define CHBA_WAIT_CYC        ((`CHBA_WAIT_NS * `CHBA_CLK_MHZ + 999) / 1000)
`define CHBA_SYNC_RESET_VAL  1'b1

`endif

// ==== rtl/chba_pkg.sv ====
// types of the display-controller host bus adapter
// pin groups are carried as packed structs
package chba_pkg;

    typedef enum logic [1:0] {
        CHBA_HOST_MUX   = 2'b01,
        CHBA_HOST_DEMUX = 2'b10
    } chba_host_t;

    // asynchronous pins, all sampled through the synchroniser
    typedef struct packed {
        logic       crtc_bus_request_n;
        logic       host_bus_grant_n;
        logic       host_addr_strobe_n;
        logic       preempt_req;
        logic       crtc_addr_strobe_n;
        logic       crtc_data_strobe_n;
        logic       crtc_write;
        logic       host_rd_n;
        logic       host_cs_n;
        logic       irq_ack_cycle_n;
        logic       chain_enable_in;
        logic       high_byte_strobe_n;
        logic       low_byte_strobe_n;
        logic [7:0] ad_low;
    } chba_pins_t;

    // a pin driven only while its enable is high
    typedef struct packed {
        logic value;
        logic oe;
    } chba_drive_t;

endpackage

// ==== test/chba_host_model.sv ====
// host bus model: answers the adapter's bus request with a grant
// assumes the request level is the adapter's open-drain enable
`timescale 1ns/1ps
module chba_host_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // arbitration
    input  wire logic       req_low_i,
    input  wire logic [3:0] lag_i,
    output logic            grant_n_o,
    output logic            host_as_n_o
);
    logic [3:0] cnt_reg;
    always_ff @(posedge mclk_i) begin
        if (reset_i || !req_low_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    assign grant_n_o   = (cnt_reg == 4'h0);
    // own cycle runs on for lag_i clocks, so grant alone is not enough
    assign host_as_n_o = (cnt_reg > lag_i);
endmodule

// ==== test/test_crtc_host_bus_adapter.sv ====
// self-checking bench of the host bus adapter
// assumes chba_host_model stands in for the host arbitration
`timescale 1ns/1ps
module test_crtc_host_bus_adapter
    import chba_pkg::*;
;
    localparam int WC = 25;
    logic mclk_i = 1'b0, reset_i = 1'b1, lin = 1'b0, sup = 1'b0, den = 1'b0;
    logic wr_n = 1'b1, ale = 1'b0, dir = 1'b0, g_n, h_as_n;
    logic [3:0] lag = 4'h1;
    logic [7:0] upper_o, up_exp = 8'h00;
    logic upper_oe, hold, gc_n, ack_n, owner, wt, vec, xcv;
    logic [31:0] seed = 32'h0000_0043;
    int err_total = 0, cmp_count = 0, cyc_n = 0, n, i, k;
    chba_host_t kind = CHBA_HOST_MUX;
    chba_pins_t p, pins_w;
    chba_drive_t ds, as, wnr, mio, hbs, lbs, brq;

    always #2.5 mclk_i = ~mclk_i;
    always_comb begin
        pins_w = p;
        pins_w.host_bus_grant_n = g_n;
        pins_w.host_addr_strobe_n = h_as_n;
    end

    chba_adapter #(.BR_HOLD_CYC(4), .WAIT_CYC(WC)) DUT (
        .mclk_i(mclk_i), .reset_i(reset_i), .host_kind_i(kind), .linear_mode_i(lin),
        .vector_suppress_i(sup), .display_enable_i(den), .pins_i(pins_w),
        .host_wr_n_i(wr_n), .ale_i(ale), .xfer_direction_i(dir), .upper_addr_o(upper_o),
        .upper_addr_oe_o(upper_oe), .data_strobe_n_o(ds), .addr_strobe_n_o(as),
        .write_not_read_o(wnr), .mem_io_o(mio), .high_byte_strobe_n_o(hbs),
        .low_byte_strobe_n_o(lbs), .hold_o(hold), .host_bus_request_n_o(brq),
        .grant_confirm_n_o(gc_n), .bus_ack_in_n_o(ack_n), .bus_owner_o(owner),
        .wait_o(wt), .xcvr_en_o(xcv), .vector_en_o(vec));
    chba_host_model host (.mclk_i(mclk_i), .reset_i(reset_i), .req_low_i(brq.oe),
        .lag_i(lag), .grant_n_o(g_n), .host_as_n_o(h_as_n));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_upper(input logic [7:0] ad, input logic l);
        return l ? ad : {1'b0, ad[6:0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge mclk_i);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // whole run is near 400 cycles; ceiling leaves a wide margin
    always @(posedge mclk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 8000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    initial begin
        p = '1;
        p.preempt_req = 1'b0;
        p.chain_enable_in = 1'b0;
        p.crtc_write = 1'b0;
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        cyc(2);
        chk("grant_confirm_n", 1, gc_n);
        chk("bus_owner", 0, owner);
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            k = rnd();
            @(posedge mclk_i);
            p.host_rd_n <= k[0];
            wr_n <= k[1];
            ale <= k[2];
            dir <= k[3];
            cyc(5);
            chk("data_strobe", k[0] & k[1], ds.value);
            chk("addr_strobe", !k[2], as.value);
            chk("write_not_read", !k[3], wnr.value);
            chk("strobe_oe", 3'h7, {ds.oe, as.oe, wnr.oe});
            chk("mem_io", 2'h1, {mio.oe, mio.value});
        end
        @(posedge mclk_i);
        p.host_rd_n <= 1'b1;
        p.host_cs_n <= 1'b0;
        cyc(5);
        @(posedge mclk_i);
        p.host_rd_n <= 1'b0;
        for (n = 0; n < 20 && wt !== 1'b1; n++) cyc(1);
        for (n = 0; n < 60 && wt === 1'b1; n++) cyc(1);
        chk("wait_len", 8'(WC), 8'(n));
        @(posedge mclk_i);
        p.host_rd_n <= 1'b1;
        p.host_cs_n <= 1'b1;
        p.crtc_bus_request_n <= 1'b0;
        cyc(8);
        chk("hold_refused", 0, hold);
        @(posedge mclk_i);
        den <= 1'b1;
        cyc(8);
        chk("hold", 1, hold);
        @(posedge mclk_i);
        p.crtc_bus_request_n <= 1'b1;
        kind <= CHBA_HOST_DEMUX;
        p.irq_ack_cycle_n <= 1'b0;
        p.chain_enable_in <= 1'b1;
        cyc(8);
        chk("hold_off", 0, hold);
        $display("test mux_host done");
        for (i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            p.high_byte_strobe_n <= i[0];
            p.low_byte_strobe_n <= i[1];
            sup <= i[2];
            cyc(5);
            chk("data_strobe", {1'b1, i[0] | i[1]}, {ds.oe, ds.value});
            chk("addr_strobe", 0, as.value);
            chk("vector_en", !(i[0] | i[1] | i[2]), vec);
        end
        $display("test demux_slave done");
        for (i = 0; i < 3; i++) begin
            k = rnd();
            @(posedge mclk_i);
            lag <= {1'b0, k[2:0]} + 4'h1;
            p.crtc_data_strobe_n <= k[3];
            lin <= i[0];
            p.crtc_bus_request_n <= 1'b0;
            for (n = 0; n < 100 && gc_n !== 1'b0; n++) cyc(1);
            chk("bus_ack_in_n", 0, ack_n);
            for (n = 0; n < 20 && brq.oe === 1'b1; n++) cyc(1);
            chk("request_hold", 1, n >= 4);
            cyc(3);
            chk("owner", 1, owner);
            chk("upper_oe", 1, upper_oe);
            chk("ds_oe", 0, ds.oe);
            chk("byte_strobes", {2'h3, {2{k[3]}}},
                {hbs.oe, lbs.oe, hbs.value, lbs.value});
            chk("xcvr_en", !k[3], xcv);
            @(posedge mclk_i);
            p.ad_low <= k[15:8];
            p.crtc_write <= (i == 2);
            p.crtc_addr_strobe_n <= 1'b0;
            if (i != 2) up_exp = exp_upper(k[15:8], i[0]);
            cyc(5);
            @(posedge mclk_i);
            p.crtc_addr_strobe_n <= 1'b1;
            p.preempt_req <= (i == 1);
            cyc(6);
            chk("upper_addr", up_exp, upper_o);
            chk("ack_held", i == 1, gc_n);
            chk("owner_kept", 1, owner);
            chk("strobe_gate", 2'h1, {ds.oe, hbs.oe});
            @(posedge mclk_i);
            p.crtc_bus_request_n <= 1'b1;
            cyc(6);
            chk("release", 2'h1, {owner, ack_n});
            chk("xcvr_off", 0, xcv);
            chk("upper_oe_off", 0, upper_oe);
            @(posedge mclk_i);
            p.preempt_req <= 1'b0;
            cyc(4);
        end
        $display("test arbitration done");
        close_out();
    end
endmodule
